// ---- src/mies_pkg.sv ----
/*
 * Shared types and constants for the instruction execution core:
 * opcodes, the instruction carrier, register offsets, status bit
 * positions and reset values.
 * Assumes a single clock domain and an 8-bit data path.
 */
package mies_pkg;

   localparam int unsigned PC_W       = 12;
   localparam int unsigned DATA_W     = 8;
   localparam int unsigned DMEM_DEPTH = 64;
   localparam int unsigned STACK_DEPTH = 8;
   localparam int unsigned WDT_PRE_W  = 8;
   localparam int unsigned WDT_CNT_W  = 8;

   // register port offsets; data memory sits below DMEM_DEPTH
   localparam logic [7:0] REG_ACC    = 8'hf0;
   localparam logic [7:0] REG_STATUS = 8'hf1;
   localparam logic [7:0] REG_PC_LO  = 8'hf2;
   localparam logic [7:0] REG_PC_HI  = 8'hf3;
   localparam logic [7:0] REG_CTRL   = 8'hf4;

   // operand address that aliases the low program counter byte
   localparam logic [7:0] ADDR_PC_LOW = 8'h7f;

   // status and control bit positions
   localparam int unsigned ST_CARRY = 0;
   localparam int unsigned ST_HALF  = 1;
   localparam int unsigned ST_ZERO  = 2;
   localparam int unsigned ST_TIMEOUT = 3;
   localparam int unsigned ST_SLEEP   = 4;
   localparam int unsigned ST_GIE   = 5;
   localparam int unsigned CTRL_WDT_EN = 0;

   localparam logic       RST_WDT_EN  = 1'b1;
   localparam logic [3:0] BCD_LIMIT   = 4'h9;
   localparam logic [3:0] BCD_FIX     = 4'h6;
   localparam logic [7:0] ONE_BYTE    = 8'h01;

   typedef enum logic [4:0] {
      OP_IDLE, OP_CALL, OP_BRANCH, OP_CLR_BYTE, OP_CLR_BIT,
      OP_WDT_CLEAR, OP_WDT_PRE_FIRST, OP_WDT_PRE_SECOND,
      OP_INVERT, OP_INVERT_TO_WORK, OP_DECIMAL_ADJUST,
      OP_MINUS_ONE, OP_MINUS_ONE_TO_WORK, OP_PLUS_ONE, OP_PLUS_ONE_TO_WORK,
      OP_COPY_MEM_TO_WORK, OP_COPY_IMM_TO_WORK, OP_COPY_WORK_TO_MEM,
      OP_OR_MEM_TO_WORK, OP_OR_IMM_TO_WORK, OP_OR_TO_MEMORY,
      OP_SUB_BACK, OP_SUB_BACK_IMM, OP_IRQ_EXIT, OP_SLEEP,
      OP_ROTATE_LEFT, OP_ROTATE_LEFT_TO_WORK
   } mies_op_t;

   typedef enum logic [1:0] {PRE_NONE, PRE_FIRST, PRE_SECOND} mies_pre_t;

   typedef struct packed {
      mies_op_t          op;
      logic [7:0]        addr;
      logic [2:0]        bit_sel;
      logic [7:0]        imm;
      logic [PC_W-1:0]   target;
   } mies_instr_t;

endpackage

// ---- src/mies_stack.sv ----
/*
 * Return address stack for the execution core.
 * Assumes push and pop never come in the same cycle; a push past
 * the last level wraps and overwrites the oldest entry.
 */
`timescale 1ns/1ps
`default_nettype none

module mies_stack #(
   parameter int unsigned WIDTH = 12,
   parameter int unsigned DEPTH = 8
) (
   // clock and reset
   input  wire logic             i_sys_clk,
   input  wire logic             i_arst_n,
   // stack control
   input  wire logic             i_push,
   input  wire logic             i_pop,
   input  wire logic [WIDTH-1:0] i_push_data,
   output logic      [WIDTH-1:0] o_top
);

   localparam int unsigned PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   typedef struct packed {
      logic [PTR_W-1:0] ptr;
   } mies_stack_state_t;

   mies_stack_state_t st;
   mies_stack_state_t next_st;
   logic [WIDTH-1:0]  slot [DEPTH];
   logic [PTR_W-1:0]  top_idx;

   always_comb begin
      next_st = st;
      top_idx = st.ptr - PTR_W'(1);
      if (i_push) begin
         next_st.ptr = (st.ptr == PTR_W'(DEPTH - 1)) ? '0 : st.ptr + PTR_W'(1);
      end else if (i_pop) begin
         next_st.ptr = (st.ptr == '0) ? PTR_W'(DEPTH - 1) : top_idx;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // entries hold no reset: only read after a push
   always_ff @(posedge i_sys_clk) begin
      if (i_push) begin
         slot[st.ptr] <= i_push_data;
      end
   end

   assign o_top = slot[(st.ptr == '0) ? PTR_W'(DEPTH - 1) : top_idx];

endmodule // mies_stack

`default_nettype wire

// ---- src/mies_core.sv ----
/*
 * Execution core for one subset of an 8-bit instruction set: calls,
 * branches, clears, watchdog clears, complement, decimal adjust,
 * increment, decrement, moves, OR, returns, sleep and left rotates.
 * Assumes one decoded instruction per valid/ready handshake, a plain
 * register port for software and an external clock gate on o_clk_stop.
 */
// Decided for this implementation: the register addresses and the strobed register port.
`timescale 1ns/1ps
`default_nettype none

module mies_core
   import mies_pkg::*;
#(
   parameter int unsigned   DEPTH      = DMEM_DEPTH,
   parameter int unsigned   STACK_LVLS = STACK_DEPTH,
   parameter int unsigned   PRE_W      = WDT_PRE_W,
   parameter int unsigned   CNT_W      = WDT_CNT_W,
   parameter logic [PC_W-1:0] IRQ_VECTOR = 12'h004
) (
   // clock and reset
   input  wire logic              i_sys_clk,
   input  wire logic              i_arst_n,
   // instruction stream
   input  wire logic              i_instr_valid,
   input  wire mies_instr_t       i_instr,
   output logic                   o_instr_ready,
   // system events
   input  wire logic              i_irq_pending,
   input  wire logic              i_wake,
   output logic                   o_irq_ack,
   output logic                   o_wdt_reset,
   output logic                   o_clk_stop,
   // visible state
   output logic      [PC_W-1:0]   o_pc,
   output logic      [7:0]        o_working_register,
   output logic                   o_global_irq_enable,
   // register port
   input  wire logic [7:0]        i_reg_addr,
   input  wire logic [7:0]        i_reg_wdata,
   input  wire logic              i_reg_wr,
   input  wire logic              i_reg_rd,
   output logic      [7:0]        o_reg_rdata
);

   typedef struct packed {
      logic [PC_W-1:0]  pc;
      logic [7:0]       acc;
      logic             carry;
      logic             half_carry_flag;
      logic             zero;
      logic             watchdog_timeout_flag;
      logic             sleep_entered_flag;
      logic             global_irq_enable;
      logic             ready;
      logic             asleep;
      logic             wdt_en;
      logic             irq_ack;
      logic             wdt_reset;
      logic [PRE_W-1:0] prescaler;
      logic [CNT_W-1:0] watchdog_counter;
      mies_pre_t        last_pre;
      logic [7:0]       rdata;
   } mies_state_t;

   mies_state_t     st;
   mies_state_t     next_st;
   logic [7:0]      mem [DEPTH];
   logic            take;
   logic [7:0]      opnd;
   logic [7:0]      res;
   logic            wr_mem;
   logic            wr_acc;
   logic            upd_z;
   logic            mem_we;
   logic [7:0]      mem_wa;
   logic [7:0]      mem_wd;
   logic            push;
   logic            pop;
   logic [PC_W-1:0] stack_top;
   logic            wdt_clear;
   logic            timeout;
   logic            lo_fix;
   logic            hi_fix;
   logic [7:0]      status_byte;

   // operand read: memory, the pc low alias, or zero beyond memory
   function automatic logic [7:0] read_byte(input logic [7:0] a);
      if (a == ADDR_PC_LOW) begin
         return st.pc[7:0];
      end else if (a < 8'(DEPTH)) begin
         return mem[a[$clog2(DEPTH)-1:0]];
      end
      return 8'h00;
   endfunction

   mies_stack #(
      .WIDTH (PC_W),
      .DEPTH (STACK_LVLS)
   ) u_stack (
      .i_sys_clk   (i_sys_clk),
      .i_arst_n    (i_arst_n),
      .i_push      (push),
      .i_pop       (pop),
      .i_push_data (st.pc + PC_W'(1)),
      .o_top       (stack_top)
   );

   assign take    = i_instr_valid && st.ready;
   // a process, so pc and memory changes also refresh the operand
   always_comb opnd = read_byte(i_instr.addr);
   assign timeout = st.wdt_en && (&st.prescaler) && (&st.watchdog_counter);
   assign lo_fix  = (st.acc[3:0] > BCD_LIMIT) || st.half_carry_flag;
   assign hi_fix  = (st.acc[7:4] > BCD_LIMIT) || st.carry;
   assign status_byte = {2'b00, st.global_irq_enable, st.sleep_entered_flag,
                         st.watchdog_timeout_flag, st.zero, st.half_carry_flag, st.carry};

   always_comb begin
      next_st           = st;
      next_st.irq_ack   = 1'b0;
      next_st.wdt_reset = 1'b0;
      next_st.rdata     = 8'h00;
      res       = 8'h00;
      wr_mem    = 1'b0;
      wr_acc    = 1'b0;
      upd_z     = 1'b0;
      mem_we    = 1'b0;
      mem_wa    = i_instr.addr;
      mem_wd    = 8'h00;
      push      = 1'b0;
      pop       = 1'b0;
      wdt_clear = 1'b0;

      // second cycle of a two-cycle instruction ends here
      if (!st.ready && !st.asleep) begin
         next_st.ready = 1'b1;
      end

      if (i_reg_rd) begin
         if (i_reg_addr < 8'(DEPTH)) begin
            next_st.rdata = read_byte(i_reg_addr);
         end else if (i_reg_addr == REG_ACC) begin
            next_st.rdata = st.acc;
         end else if (i_reg_addr == REG_STATUS) begin
            next_st.rdata = status_byte;
         end else if (i_reg_addr == REG_PC_LO) begin
            next_st.rdata = st.pc[7:0];
         end else if (i_reg_addr == REG_PC_HI) begin
            next_st.rdata = 8'(st.pc >> 8);
         end else if (i_reg_addr == REG_CTRL) begin
            next_st.rdata = {7'h00, st.wdt_en};
         end
      end

      // software writes first; an instruction in the same cycle overrides
      if (i_reg_wr) begin
         if (i_reg_addr < 8'(DEPTH)) begin
            mem_we = 1'b1;
            mem_wa = i_reg_addr;
            mem_wd = i_reg_wdata;
         end else if (i_reg_addr == REG_ACC) begin
            next_st.acc = i_reg_wdata;
         end else if (i_reg_addr == REG_STATUS) begin
            next_st.carry             = i_reg_wdata[ST_CARRY];
            next_st.half_carry_flag   = i_reg_wdata[ST_HALF];
            next_st.zero              = i_reg_wdata[ST_ZERO];
            next_st.global_irq_enable = i_reg_wdata[ST_GIE];
         end else if (i_reg_addr == REG_CTRL) begin
            next_st.wdt_en = i_reg_wdata[CTRL_WDT_EN];
         end
      end

      next_st.prescaler = st.prescaler + PRE_W'(1);
      if (&st.prescaler) begin
         next_st.watchdog_counter = st.watchdog_counter + CNT_W'(1);
      end

      if (take) begin
         next_st.pc = st.pc + PC_W'(1);
         case (i_instr.op)
            OP_CALL: begin
               push          = 1'b1;
               next_st.pc    = i_instr.target;
               next_st.ready = 1'b0;
            end
            OP_BRANCH: begin
               next_st.pc    = i_instr.target;
               next_st.ready = 1'b0;
            end
            OP_CLR_BYTE: begin
               wr_mem = 1'b1;
            end
            OP_CLR_BIT: begin
               res    = opnd & ~(ONE_BYTE << i_instr.bit_sel);
               wr_mem = 1'b1;
            end
            OP_WDT_CLEAR: begin
               wdt_clear = 1'b1;
            end
            OP_WDT_PRE_FIRST: begin
               // only a preceding second half completes the pair
               if (st.last_pre == PRE_SECOND) begin
                  wdt_clear        = 1'b1;
                  next_st.last_pre = PRE_NONE;
               end else begin
                  next_st.last_pre = PRE_FIRST;
               end
            end
            OP_WDT_PRE_SECOND: begin
               if (st.last_pre == PRE_FIRST) begin
                  wdt_clear        = 1'b1;
                  next_st.last_pre = PRE_NONE;
               end else begin
                  next_st.last_pre = PRE_SECOND;
               end
            end
            OP_INVERT, OP_INVERT_TO_WORK: begin
               res    = ~opnd;
               upd_z  = 1'b1;
               wr_acc = (i_instr.op == OP_INVERT_TO_WORK);
               wr_mem = !wr_acc;
            end
            OP_DECIMAL_ADJUST: begin
               res = st.acc + {(hi_fix ? BCD_FIX : 4'h0),
                               (lo_fix ? BCD_FIX : 4'h0)};
               next_st.carry = st.carry | hi_fix;
               wr_mem        = 1'b1;
            end
            OP_MINUS_ONE, OP_MINUS_ONE_TO_WORK: begin
               res    = opnd - ONE_BYTE;
               upd_z  = 1'b1;
               wr_acc = (i_instr.op == OP_MINUS_ONE_TO_WORK);
               wr_mem = !wr_acc;
            end
            OP_PLUS_ONE, OP_PLUS_ONE_TO_WORK: begin
               res    = opnd + ONE_BYTE;
               upd_z  = 1'b1;
               wr_acc = (i_instr.op == OP_PLUS_ONE_TO_WORK);
               wr_mem = !wr_acc;
            end
            OP_COPY_MEM_TO_WORK: begin
               res    = opnd;
               wr_acc = 1'b1;
            end
            OP_COPY_IMM_TO_WORK: begin
               res    = i_instr.imm;
               wr_acc = 1'b1;
            end
            OP_COPY_WORK_TO_MEM: begin
               res    = st.acc;
               wr_mem = 1'b1;
            end
            OP_OR_MEM_TO_WORK, OP_OR_TO_MEMORY: begin
               res    = st.acc | opnd;
               upd_z  = 1'b1;
               wr_mem = (i_instr.op == OP_OR_TO_MEMORY);
               wr_acc = !wr_mem;
            end
            OP_OR_IMM_TO_WORK: begin
               res    = st.acc | i_instr.imm;
               upd_z  = 1'b1;
               wr_acc = 1'b1;
            end
            OP_SUB_BACK, OP_SUB_BACK_IMM: begin
               pop           = 1'b1;
               next_st.pc    = stack_top;
               next_st.ready = 1'b0;
               res           = i_instr.imm;
               wr_acc        = (i_instr.op == OP_SUB_BACK_IMM);
            end
            OP_IRQ_EXIT: begin
               next_st.ready = 1'b0;
               if (i_irq_pending) begin
                  // return address stays stacked for the handler's exit
                  next_st.pc                = IRQ_VECTOR;
                  next_st.global_irq_enable = 1'b0;
                  next_st.irq_ack           = 1'b1;
               end else begin
                  pop                       = 1'b1;
                  next_st.pc                = stack_top;
                  next_st.global_irq_enable = 1'b1;
               end
            end
            OP_SLEEP: begin
               wdt_clear                  = 1'b1;
               next_st.sleep_entered_flag = 1'b1;
               next_st.asleep             = 1'b1;
               next_st.ready              = 1'b0;
            end
            OP_ROTATE_LEFT, OP_ROTATE_LEFT_TO_WORK: begin
               res    = {opnd[6:0], opnd[7]};
               wr_acc = (i_instr.op == OP_ROTATE_LEFT_TO_WORK);
               wr_mem = !wr_acc;
            end
            default: begin
               next_st.pc = st.pc + PC_W'(1);
            end
         endcase

         if (wr_acc) begin
            next_st.acc = res;
         end
         if (upd_z) begin
            next_st.zero = (res == 8'h00);
         end
         if (wr_mem) begin
            if (i_instr.addr == ADDR_PC_LOW) begin
               next_st.pc    = {st.pc[PC_W-1:8], res};
               next_st.ready = 1'b0;
            end else begin
               mem_we = (i_instr.addr < 8'(DEPTH));
               mem_wa = i_instr.addr;
               mem_wd = res;
            end
         end
      end

      if (wdt_clear) begin
         next_st.prescaler             = '0;
         next_st.watchdog_counter      = '0;
         next_st.watchdog_timeout_flag = 1'b0;
         if (i_instr.op != OP_SLEEP) begin
            next_st.sleep_entered_flag = 1'b0;
         end
      end

      // timeout set wins over any clear in the same cycle
      if (timeout) begin
         next_st.watchdog_timeout_flag = 1'b1;
         next_st.wdt_reset             = 1'b1;
      end
      if (st.asleep && (i_wake || timeout)) begin
         next_st.asleep = 1'b0;
         next_st.ready  = 1'b1;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         st        <= '0;
         st.ready  <= 1'b1;
         st.wdt_en <= RST_WDT_EN;
      end else begin
         st <= next_st;
      end
   end

   // memory keeps its contents through reset and sleep
   always_ff @(posedge i_sys_clk) begin
      if (mem_we) begin
         mem[mem_wa[$clog2(DEPTH)-1:0]] <= mem_wd;
      end
   end

   assign o_instr_ready       = st.ready;
   assign o_irq_ack           = st.irq_ack;
   assign o_wdt_reset         = st.wdt_reset;
   assign o_clk_stop          = st.asleep;
   assign o_pc                = st.pc;
   assign o_working_register  = st.acc;
   assign o_global_irq_enable = st.global_irq_enable;
   assign o_reg_rdata         = st.rdata;

   AST_CALL_TWO_CYCLES: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
      take && i_instr.op == OP_CALL |=> o_pc == $past(i_instr.target) && !o_instr_ready ##1 o_instr_ready)
      else $error("call did not load target in two cycles");

   AST_BRANCH_TARGET: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
      take && i_instr.op == OP_BRANCH |=> o_pc == $past(i_instr.target) && !o_instr_ready)
      else $error("branch target or dummy cycle wrong");

   AST_PRE_REPEAT_IDLE: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
      take && i_instr.op == OP_WDT_PRE_FIRST && st.last_pre != PRE_SECOND && !timeout
      |=> $stable(st.sleep_entered_flag) && $stable(st.watchdog_timeout_flag))
      else $error("lone pre-clear changed flags");

   AST_PAIR_CLEARS: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
      take && i_instr.op == OP_WDT_PRE_SECOND && st.last_pre == PRE_FIRST && !timeout
      |=> !st.sleep_entered_flag && !st.watchdog_timeout_flag && st.watchdog_counter == '0)
      else $error("pre-clear pair did not clear");

   AST_PLUS_ONE_WORK: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
      take && i_instr.op == OP_PLUS_ONE_TO_WORK
      |=> o_working_register == $past(opnd) + ONE_BYTE && st.zero == (o_working_register == 8'h00))
      else $error("increment to work register wrong");

   AST_SLEEP_FLAGS: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
      take && i_instr.op == OP_SLEEP && !timeout
      |=> o_clk_stop && st.sleep_entered_flag && !st.watchdog_timeout_flag && st.prescaler == '0)
      else $error("sleep entry flags wrong");

   AST_EXIT_ENABLES: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
      take && i_instr.op == OP_IRQ_EXIT && !i_irq_pending |=> o_global_irq_enable && !o_irq_ack)
      else $error("interrupt exit did not enable");

   AST_EXIT_PENDING: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
      take && i_instr.op == OP_IRQ_EXIT && i_irq_pending |=> o_pc == IRQ_VECTOR && o_irq_ack)
      else $error("pending interrupt not serviced");

   AST_PC_LOW_WRITE: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
      take && i_instr.op == OP_COPY_WORK_TO_MEM && i_instr.addr == ADDR_PC_LOW
      |=> o_pc[7:0] == $past(st.acc) && !o_instr_ready ##1 o_instr_ready)
      else $error("pc low write not two cycles");

endmodule // mies_core

`default_nettype wire

// ---- bench/mies_core_bench.sv ----
/*
 * Bench for mies_core: a random instruction stream is checked against a
 * behavioural model after each instruction.
 * Assumes mies_pkg and the core are compiled first; the watchdog runs
 * only in the final timeout check.
 */
`timescale 1ns/1ps
`default_nettype none

module mies_core_bench;
   import mies_pkg::*;
   logic            clk = 1'b0, rst_n = 1'b0, vld = 1'b0, irq = 1'b0, wake = 1'b0;
   logic            wr = 1'b0, rd = 1'b0, rdy, stop, gie_o, ack, wdr;
   logic [7:0]      ra = 8'h00, wd = 8'h00, rdat, acc_o, acc = 8'h00, res;
   logic [PC_W-1:0] pc_o, pc = '0;
   mies_instr_t     ins = '0;
   mies_op_t        o;
   logic [7:0]      m [8];
   logic            c, h, z, to = 1'b0, slp = 1'b0, gie;
   int              fails = 0, checks_done = 0, pend = 0, q[$], wn;
   bit [31:0]       seed = 32'hf13a29e9;

   mies_core i_mies_core (.i_sys_clk(clk), .i_arst_n(rst_n), .i_instr_valid(vld), .i_instr(ins),
      .o_instr_ready(rdy), .i_irq_pending(irq), .i_wake(wake), .o_irq_ack(ack), .o_wdt_reset(wdr),
      .o_clk_stop(stop), .o_pc(pc_o), .o_working_register(acc_o), .o_global_irq_enable(gie_o),
      .i_reg_addr(ra), .i_reg_wdata(wd), .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdat));

   initial forever #2.5 clk = ~clk;

   function automatic void nxt();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
   endfunction

   task automatic test_done();
      $display("checks %0d fails %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic chk(logic [15:0] got, logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // a spare edge after each strobe keeps one assignment per time step
   task automatic wrr(logic [7:0] a, logic [7:0] d);
      ra <= a; wd <= d; wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      @(posedge clk);
   endtask

   // read data stand only in the cycle after the strobe: look there, settled
   task automatic rdr(logic [7:0] a, logic [7:0] e);
      ra <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk(rdat, e);
   endtask

   task automatic op(logic [7:0] a, logic [7:0] im, logic [PC_W-1:0] t);
      int n;
      logic ak;
      bit wm;
      bit tc;
      logic [PC_W-1:8] ph;
      ins <= '{op: o, addr: a, bit_sel: im[2:0], imm: im, target: t};
      vld <= 1'b1;
      @(posedge clk);
      vld <= 1'b0;
      // look 1 ns past each edge, once registered outputs have settled
      for (n = 0; n < 40; n++) begin
         #1;
         if (n == 0) ak = ack;
         if (rdy === 1'b1) break;
         wake <= stop;
         @(posedge clk);
      end
      wake <= 1'b0;
      if (n == 40) begin fails++; test_done(); end
      res = (a == 8'h7f) ? pc[7:0] : m[a[2:0]];
      ph = pc[PC_W-1:8];
      pc = pc + 1'b1;
      case (o)
         OP_CALL: begin q.push_back(pc); pc = t; end
         OP_BRANCH: pc = t;
         OP_CLR_BYTE: res = 8'h00;
         OP_CLR_BIT: res[im[2:0]] = 1'b0;
         OP_WDT_CLEAR: {to, slp} = 2'b00;
         OP_WDT_PRE_FIRST, OP_WDT_PRE_SECOND: if (pend != 0 && pend != o) begin
            {to, slp} = 2'b00; pend = 0; end else pend = o;
         OP_INVERT, OP_INVERT_TO_WORK: res = ~res;
         OP_DECIMAL_ADJUST: begin
            res = acc + ((acc[3:0] > 9 || h) ? 8'h06 : 8'h00);
            if (acc[7:4] > 9 || c) begin res = res + 8'h60; c = 1'b1; end
         end
         OP_MINUS_ONE, OP_MINUS_ONE_TO_WORK: res = res - 8'h01;
         OP_PLUS_ONE, OP_PLUS_ONE_TO_WORK: res = res + 8'h01;
         OP_SLEEP: {to, slp} = 2'b01;
         OP_COPY_IMM_TO_WORK, OP_SUB_BACK_IMM: res = im;
         OP_COPY_WORK_TO_MEM: res = acc;
         OP_OR_MEM_TO_WORK, OP_OR_TO_MEMORY: res = acc | res;
         OP_OR_IMM_TO_WORK: res = acc | im;
         OP_ROTATE_LEFT, OP_ROTATE_LEFT_TO_WORK: res = {res[6:0], res[7]};
         default: ;
      endcase
      if (o inside {OP_SUB_BACK, OP_SUB_BACK_IMM} || (o == OP_IRQ_EXIT && !irq)) pc = q.pop_back();
      if (o == OP_IRQ_EXIT) begin gie = !irq; if (irq) pc = 12'h004; end
      if (o inside {OP_INVERT_TO_WORK, OP_MINUS_ONE_TO_WORK, OP_PLUS_ONE_TO_WORK, OP_COPY_MEM_TO_WORK,
         OP_COPY_IMM_TO_WORK, OP_OR_MEM_TO_WORK, OP_OR_IMM_TO_WORK, OP_SUB_BACK_IMM, OP_ROTATE_LEFT_TO_WORK})
         acc = res;
      wm = o inside {OP_CLR_BYTE, OP_CLR_BIT, OP_INVERT, OP_DECIMAL_ADJUST, OP_MINUS_ONE, OP_PLUS_ONE,
         OP_COPY_WORK_TO_MEM, OP_OR_TO_MEMORY, OP_ROTATE_LEFT};
      // the pc low alias keeps the high byte of the pc before the increment
      if (wm && a == 8'h7f) pc = {ph, res};
      else if (wm) m[a[2:0]] = res;
      tc = (o inside {OP_CALL, OP_BRANCH, OP_SUB_BACK, OP_SUB_BACK_IMM, OP_IRQ_EXIT}) || (wm && a == 8'h7f);
      if (o != OP_SLEEP) chk(16'(n), 16'(tc));
      chk(16'(ak), 16'(o == OP_IRQ_EXIT && irq));
      if (o inside {OP_INVERT, OP_INVERT_TO_WORK, OP_MINUS_ONE, OP_MINUS_ONE_TO_WORK, OP_PLUS_ONE,
         OP_PLUS_ONE_TO_WORK, OP_OR_MEM_TO_WORK, OP_OR_IMM_TO_WORK, OP_OR_TO_MEMORY}) z = (res == 8'h00);
      chk(pc_o, pc);
      chk(acc_o, acc);
      chk(gie_o, gie);
      rdr(8'hf1, {2'b00, gie, slp, to, z, h, c});
      rdr(a, (a == 8'h7f) ? 8'h00 : m[a[2:0]]);
   endtask

   initial begin
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      wrr(8'hf4, 8'h00); // watchdog off keeps the timeout flag predictable
      for (int i = 0; i < 8; i++) begin
         nxt();
         m[i] = seed[7:0];
         wrr(i[7:0], m[i]);
      end
      nxt();
      {gie, z, h, c} = {seed[5], seed[2:0]};
      wrr(8'hf1, seed[7:0]);
      rdr(8'h80, 8'h00);
      for (int i = 0; i < 400; i++) begin
         nxt();
         o = mies_op_t'(seed[4:0] % 27);
         if ((o inside {OP_SUB_BACK, OP_SUB_BACK_IMM, OP_IRQ_EXIT} && q.size() == 0) ||
            (o == OP_CALL && q.size() == 8)) o = OP_IDLE;
         irq <= seed[9];
         @(posedge clk);
         op((seed[15:14] == 2'b00) ? 8'h7f : {5'b00000, seed[12:10]}, seed[23:16], seed[31:20]);
      end
      o = OP_COPY_WORK_TO_MEM;
      op(8'h7f, 8'h00, 12'h000);
      // watchdog on: a full period from a clear to the one-cycle timeout pulse
      wrr(8'hf4, 8'h01);
      ins <= '{op: OP_WDT_CLEAR, addr: 8'h00, bit_sel: 3'h0, imm: 8'h00, target: '0};
      vld <= 1'b1;
      @(posedge clk);
      vld <= 1'b0;
      for (wn = 0; wn < 70000; wn++) begin
         @(posedge clk);
         #1;
         if (wdr === 1'b1) break;
      end
      if (wn == 70000) fails++;
      chk(16'(wn), 16'((1 << (WDT_PRE_W + WDT_CNT_W)) - 1));
      @(posedge clk);
      #1;
      chk(16'(wdr), 16'h0000);
      {to, slp} = 2'b10;
      rdr(8'hf1, {2'b00, gie, slp, to, z, h, c});
      test_done();
   end
endmodule // mies_core_bench

`default_nettype wire
